// [rtl/uapit_top.sv]
// Interrupt control, clock generation, counter/timer and I/O ports of the serial device.
// Operation
// RULE1: Active-low interrupt request asserts when any of eight enabled events is active.
// RULE2: Mask register enables or disables each interrupting condition individually.
// RULE3: Status register shows all active conditions regardless of mask.
// RULE4: Acknowledge with pending interrupt drives vector register and transfer acknowledge.
// RULE5: Transfer acknowledge asserts each cycle once write latched or read data valid.
// RULE6: Five output pins may serve as discrete interrupt outputs.
// RULE7: Rate generator yields eighteen rates, 50 to 115.2k baud, at sixteen times.
// RULE8: Four clock selectors pick generator rate, counter output or external input.
// RULE9: Sixteen-bit counter loaded from upper and lower presets, three modes.
// RULE10: Timer mode gives square wave; counter mode gives single delay.
// RULE11: Timeout mode lets receiver activity start and stop the counter.
// RULE12: Counter counts down and flags status at every zero pass.
// RULE13: Counter output drives an output pin or a clock selector.
// RULE14: Counter obeys start, stop, write, preset, read value, timeout commands.
// RULE15: Change detection samples at 38.4 kHz, needs two samples at new level.
// RULE16: Read at 0xD gives pin levels, bit 7 one, bit 6 acknowledge.
// RULE17: Four detectors set change bits on transitions lasting 25 to 50 us.
// RULE18: Reading the change register clears all change bits.
// RULE19: Any input change can be enabled as an interrupt.
// RULE20: General-purpose output pin drives inverse of its latch bit.
// RULE21: Write at 0xE sets latch bits written with one.
// RULE22: Write at 0xF clears latch bits written with one.
// RULE23: Interrupt-type output pins become open-drain, driving only low.
// RULE24: Input pins are synchronised before detection and host reads.
`timescale 1ns/100ps
`default_nettype none
`include "uapit_params.svh"

module uapit_top #(
	parameter int CLK_HZ = `UAPIT_CLK_HZ
) (
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       cs_n_in,
	input  wire logic       rw_in,
	input  wire logic [3:0] addr_in,
	input  wire logic [7:0] data_in,
	input  wire logic       irq_ack_n_in,
	input  wire logic [5:0] in_pin_in,
	input  wire logic       tx_rdy_a_in,
	input  wire logic       rx_rdy_a_in,
	input  wire logic       brk_a_in,
	input  wire logic       tx_rdy_b_in,
	input  wire logic       rx_rdy_b_in,
	input  wire logic       brk_b_in,
	input  wire logic       rx_activity_in,
	output logic      [7:0] data_out,
	output logic            data_oe_b_out,
	output logic            xfer_ack_n_out,
	output logic            irq_n_out,
	output logic      [7:0] out_pin_out,
	output logic      [7:0] out_pin_oe_b_out,
	output logic      [3:0] rate_tick_out
);
	import uapit_pkg::*;

	localparam int SAMPLE_DIV = CLK_HZ / `UAPIT_SAMPLE_HZ;

	uapit_state_t   q;
	uapit_state_t   next_q;
	uapit_ct_mode_t ct_mode;
	logic [15:0]    ct_value;
	logic           ct_wave;
	logic           ct_zero;

	// Sixteen-times clock divisor for each standard rate, in tenths of a baud.
	function automatic logic [16:0] uapit_rate_div(input logic [4:0] idx);
		int r;
		case (idx)
			5'h00:   r = 500;
			5'h01:   r = 750;
			5'h02:   r = 1100;
			5'h03:   r = 1345;
			5'h04:   r = 1500;
			5'h05:   r = 3000;
			5'h06:   r = 6000;
			5'h07:   r = 12000;
			5'h08:   r = 18000;
			5'h09:   r = 20000;
			5'h0A:   r = 24000;
			5'h0B:   r = 48000;
			5'h0C:   r = 72000;
			5'h0D:   r = 96000;
			5'h0E:   r = 192000;
			5'h0F:   r = 384000;
			5'h10:   r = 576000;
			default: r = 1152000;
		endcase
		uapit_rate_div = 17'((longint'(CLK_HZ) * 10) / (16 * r));
	endfunction

	// RULE9 mode from controls
	assign ct_mode = q.ct_timeout ? UAPIT_CT_TIMEOUT :
		(q.aux_control_reg[`UAPIT_AUX_CT_TIMER] ? UAPIT_CT_TIMER : UAPIT_CT_COUNTER);

	uapit_ctimer u_ctimer (
		.clk_in         (clk_in),
		.rst_b_in       (rst_b_in),
		.tick_in        (q.aux_control_reg[`UAPIT_AUX_CT_EXT] ?
		                 (q.ip_s2[2] & ~q.ip_s3[2]) : 1'b1),
		.mode_in        (ct_mode),
		.start_in       (q.ct_start),
		.stop_in        (q.ct_stop),
		.rx_activity_in (rx_activity_in),
		.preset_in      (q.ct_preset),
		.value_out      (ct_value),
		.wave_out       (ct_wave),
		.zero_out       (ct_zero)
	);

	// All block behaviour apart from the counter/timer in u_ctimer is computed here and registered below.
	always_comb begin
		logic [5:0]  ext_edge;
		logic        sample;
		logic [16:0] div;
		logic [3:0]  chg_set;
		logic [3:0]  chg_clr;
		logic        flag_clr;
		logic [7:0]  status;
		logic        pending;
		logic [7:0]  rd;
		ext_edge = 6'h00;
		sample   = 1'b0;
		div      = 17'h00000;
		chg_set  = 4'h0;
		chg_clr  = 4'h0;
		flag_clr = 1'b0;
		status   = 8'h00;
		pending  = 1'b0;
		rd       = 8'h00;
		next_q   = q;
		next_q.ct_start = 1'b0;
		next_q.ct_stop  = 1'b0;

		// RULE24 two-stage synchroniser
		// Only the second stage and later feed any logic.
		next_q.ip_s1 = in_pin_in;
		next_q.ip_s2 = q.ip_s1;
		next_q.ip_s3 = q.ip_s2;
		ext_edge = q.ip_s2 & ~q.ip_s3;

		// RULE15 sample tick
		if (32'(q.smp_cnt) >= SAMPLE_DIV - 1) begin
			next_q.smp_cnt = 12'h000;
			sample = 1'b1;
		end else begin
			next_q.smp_cnt = q.smp_cnt + 12'h001;
		end

		// RULE17 change detectors
		// Two matching samples filter glitches shorter than one sample period.
		for (int i = 0; i < 4; i++) begin
			if (sample) begin
				next_q.ip_prev[i] = q.ip_s2[i];
				if (q.ip_s2[i] != q.ip_acc[i] && q.ip_prev[i] == q.ip_s2[i]) begin
					next_q.ip_acc[i] = q.ip_s2[i];
					chg_set[i] = 1'b1;
				end
			end
		end

		// RULE7 rate dividers
		// RULE8 clock selectors
		// Each selector owns a divider, so rates never interfere across channels.
		for (int k = 0; k < 4; k++) begin
			div = uapit_rate_div(q.clk_sel[k]);
			next_q.rate_tick[k] = 1'b0;
			if (q.clk_sel[k] == `UAPIT_SEL_CT) begin
				// RULE13 counter as clock
				next_q.rate_tick[k] = ct_zero;
			end else if (q.clk_sel[k] == `UAPIT_SEL_EXT) begin
				case (k)
					0:       next_q.rate_tick[k] = ext_edge[4];
					1:       next_q.rate_tick[k] = ext_edge[3];
					2:       next_q.rate_tick[k] = ext_edge[2];
					default: next_q.rate_tick[k] = ext_edge[5];
				endcase
			end else if (q.rate_cnt[k] >= div - 17'h00001) begin
				next_q.rate_cnt[k] = 17'h00000;
				next_q.rate_tick[k] = 1'b1;
			end else begin
				next_q.rate_cnt[k] = q.rate_cnt[k] + 17'h00001;
			end
		end

		// RULE3 status unmasked
		// RULE19 change interrupt enable
		status = {|(q.ip_chg & q.aux_control_reg[3:0]), brk_b_in, rx_rdy_b_in, tx_rdy_b_in,
			q.ct_flag, brk_a_in, rx_rdy_a_in, tx_rdy_a_in};
		pending = |(status & q.irq_mask_reg);

		// Host bus access: one action per cycle, then hold until released.
		case (q.bus)
			UAPIT_BUS_IDLE: begin
				if (!cs_n_in) begin
					// RULE5 acknowledge each cycle
					next_q.bus = UAPIT_BUS_ACK;
					next_q.xfer_ack_n = 1'b0;
					if (rw_in) begin
						case (addr_in)
							`UAPIT_OFF_CSEL_RXA: rd = {3'h0, q.clk_sel[0]};
							`UAPIT_OFF_CSEL_TXA: rd = {3'h0, q.clk_sel[1]};
							`UAPIT_OFF_CHANGE: begin
								// RULE18 clear on read
								rd = {q.ip_acc, q.ip_chg};
								chg_clr = 4'hF;
							end
							`UAPIT_OFF_IRQ:      rd = status;
							// RULE14 read value
							`UAPIT_OFF_CT_HI:    rd = ct_value[15:8];
							`UAPIT_OFF_CT_LO:    rd = ct_value[7:0];
							`UAPIT_OFF_CSEL_RXB: rd = {3'h0, q.clk_sel[2]};
							`UAPIT_OFF_CSEL_TXB: rd = {3'h0, q.clk_sel[3]};
							`UAPIT_OFF_VECTOR:   rd = q.irq_vector_reg;
							// RULE16 input port read
							`UAPIT_OFF_INPUT:    rd = {1'b1, irq_ack_n_in, q.ip_s2};
							// RULE14 start command
							`UAPIT_OFF_OUT_SET:  next_q.ct_start = 1'b1;
							`UAPIT_OFF_OUT_CLR: begin
								// RULE14 stop command
								next_q.ct_stop = 1'b1;
								flag_clr = 1'b1;
							end
							default:             rd = 8'h00;
						endcase
						next_q.data = rd;
						next_q.data_oe_b = 1'b0;
					end else begin
						case (addr_in)
							`UAPIT_OFF_CSEL_RXA: next_q.clk_sel[0] = data_in[4:0];
							`UAPIT_OFF_CSEL_TXA: next_q.clk_sel[1] = data_in[4:0];
							`UAPIT_OFF_AUX:      next_q.aux_control_reg = data_in;
							// RULE2 mask write
							`UAPIT_OFF_IRQ:      next_q.irq_mask_reg = data_in;
							// RULE14 write presets
							`UAPIT_OFF_CT_HI:    next_q.ct_preset[15:8] = data_in;
							`UAPIT_OFF_CT_LO:    next_q.ct_preset[7:0] = data_in;
							`UAPIT_OFF_CSEL_RXB: next_q.clk_sel[2] = data_in[4:0];
							// RULE14 timeout mode set or reset
							`UAPIT_OFF_TIMEOUT:  next_q.ct_timeout = data_in[0];
							`UAPIT_OFF_CSEL_TXB: next_q.clk_sel[3] = data_in[4:0];
							`UAPIT_OFF_VECTOR:   next_q.irq_vector_reg = data_in;
							`UAPIT_OFF_OUTCFG:   next_q.out_cfg = data_in[5:0];
							// RULE21 bit set write
							`UAPIT_OFF_OUT_SET:  next_q.out_latch = q.out_latch | data_in;
							// RULE22 bit clear write
							`UAPIT_OFF_OUT_CLR:  next_q.out_latch = q.out_latch & ~data_in;
							default:             next_q.out_latch = q.out_latch;
						endcase
					end
				end else if (!irq_ack_n_in && pending) begin
					// RULE4 vector on acknowledge
					next_q.bus = UAPIT_BUS_ACK;
					next_q.xfer_ack_n = 1'b0;
					next_q.data = q.irq_vector_reg;
					next_q.data_oe_b = 1'b0;
				end
			end
			UAPIT_BUS_ACK: begin
				// Hold the answer until the host drops both strobes.
				if (cs_n_in && irq_ack_n_in) begin
					next_q.bus = UAPIT_BUS_IDLE;
					next_q.xfer_ack_n = 1'b1;
					next_q.data_oe_b = 1'b1;
				end
			end
			default: begin
				next_q.bus = UAPIT_BUS_IDLE;
				next_q.xfer_ack_n = 1'b1;
				next_q.data_oe_b = 1'b1;
			end
		endcase

		// Sticky flags: a new event in the clearing cycle survives.
		next_q.ip_chg = (q.ip_chg & ~chg_clr) | chg_set;
		// RULE12 zero pass flag
		next_q.ct_flag = (q.ct_flag & ~flag_clr) | ct_zero;

		// RULE1 single request line
		next_q.irq_n = ~pending;

		// RULE20 inverted general output
		for (int n = 0; n < 8; n++) begin
			next_q.pin_o[n] = ~next_q.out_latch[n];
			next_q.pin_oe_b[n] = 1'b0;
		end
		// RULE13 counter wave on pin
		if (q.out_cfg[`UAPIT_CFG_OP3_CTOUT]) begin
			next_q.pin_o[3] = ct_wave;
		end
		// RULE6 discrete interrupt pins
		// RULE23 open-drain drive
		// Released pins float high, so several devices may share one wire.
		if (q.out_cfg[`UAPIT_CFG_OP3_CTIRQ]) begin
			next_q.pin_o[3] = 1'b0;
			next_q.pin_oe_b[3] = ~next_q.ct_flag;
		end
		if (q.out_cfg[2]) begin
			next_q.pin_o[4] = 1'b0;
			next_q.pin_oe_b[4] = ~rx_rdy_a_in;
		end
		if (q.out_cfg[3]) begin
			next_q.pin_o[5] = 1'b0;
			next_q.pin_oe_b[5] = ~rx_rdy_b_in;
		end
		if (q.out_cfg[4]) begin
			next_q.pin_o[6] = 1'b0;
			next_q.pin_oe_b[6] = ~tx_rdy_a_in;
		end
		if (q.out_cfg[5]) begin
			next_q.pin_o[7] = 1'b0;
			next_q.pin_oe_b[7] = ~tx_rdy_b_in;
		end
	end

	// State register with synchronous reset to idle, released bus and quiet request.
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			q                <= '0;
			q.bus            <= UAPIT_BUS_IDLE;
			q.xfer_ack_n     <= 1'b1;
			q.data_oe_b      <= 1'b1;
			q.irq_n          <= 1'b1;
			q.pin_o          <= 8'hFF;
			q.irq_vector_reg <= `UAPIT_VECTOR_RST;
			q.clk_sel        <= {4{`UAPIT_CSEL_RST}};
			{q.ip_s1, q.ip_s2, q.ip_s3, q.ip_prev, q.ip_acc} <= 26'h3FFFFFF; // Pulled-up idle level.
		end else begin
			q <= next_q;
		end
	end

	assign data_out         = q.data;
	assign data_oe_b_out    = q.data_oe_b;
	assign xfer_ack_n_out   = q.xfer_ack_n;
	assign irq_n_out        = q.irq_n;
	assign out_pin_out      = q.pin_o;
	assign out_pin_oe_b_out = q.pin_oe_b;
	assign rate_tick_out    = q.rate_tick;

endmodule

`default_nettype wire

// [include/uapit_params.svh]
// Offsets, field positions, reset values and timing counts for the serial support block.
`ifndef UAPIT_PARAMS_SVH
`define UAPIT_PARAMS_SVH

`define UAPIT_CLK_HZ        100000000
`define UAPIT_SAMPLE_HZ     38400
`define UAPIT_SAMPLE_DIV    (`UAPIT_CLK_HZ / `UAPIT_SAMPLE_HZ)
`define UAPIT_NUM_RATES     18
`define UAPIT_SEL_CT        5'h12
`define UAPIT_SEL_EXT       5'h13

`define UAPIT_OFF_CSEL_RXA  4'h1
`define UAPIT_OFF_CSEL_TXA  4'h3
`define UAPIT_OFF_AUX       4'h4
`define UAPIT_OFF_CHANGE    4'h4
`define UAPIT_OFF_IRQ       4'h5
`define UAPIT_OFF_CT_HI     4'h6
`define UAPIT_OFF_CT_LO     4'h7
`define UAPIT_OFF_CSEL_RXB  4'h9
`define UAPIT_OFF_TIMEOUT   4'hA
`define UAPIT_OFF_CSEL_TXB  4'hB
`define UAPIT_OFF_VECTOR    4'hC
`define UAPIT_OFF_INPUT     4'hD
`define UAPIT_OFF_OUTCFG    4'hD
`define UAPIT_OFF_OUT_SET   4'hE
`define UAPIT_OFF_OUT_CLR   4'hF

`define UAPIT_AUX_CT_TIMER  4
`define UAPIT_AUX_CT_EXT    5
`define UAPIT_CFG_OP3_CTOUT 0
`define UAPIT_CFG_OP3_CTIRQ 1
`define UAPIT_ISR_CT        3

`define UAPIT_VECTOR_RST    8'h0F
`define UAPIT_CSEL_RST      5'h00

`endif

// [include/uapit_pkg.sv]
// Types shared by the serial support block and its counter/timer.
package uapit_pkg;

	typedef enum logic [0:0] {
		UAPIT_BUS_IDLE = 1'b0,
		UAPIT_BUS_ACK  = 1'b1
	} uapit_bus_t;

	typedef enum logic [1:0] {
		UAPIT_CT_COUNTER = 2'b00,
		UAPIT_CT_TIMER   = 2'b01,
		UAPIT_CT_TIMEOUT = 2'b10
	} uapit_ct_mode_t;

	typedef struct packed {
		logic        running;
		logic [15:0] count;
		logic        wave;
		logic        zero;
	} uapit_ct_state_t;

	typedef struct packed {
		uapit_bus_t      bus;
		logic            xfer_ack_n;
		logic            data_oe_b;
		logic [7:0]      data;
		logic            irq_n;
		logic [7:0]      irq_mask_reg;
		logic [7:0]      irq_vector_reg;
		logic [7:0]      aux_control_reg;
		logic [5:0]      out_cfg;
		logic [7:0]      out_latch;
		logic [7:0]      pin_o;
		logic [7:0]      pin_oe_b;
		logic [15:0]     ct_preset;
		logic            ct_timeout;
		logic            ct_start;
		logic            ct_stop;
		logic            ct_flag;
		logic [3:0][4:0] clk_sel;
		logic [3:0][16:0] rate_cnt;
		logic [3:0]      rate_tick;
		logic [11:0]     smp_cnt;
		logic [5:0]      ip_s1;
		logic [5:0]      ip_s2;
		logic [5:0]      ip_s3;
		logic [3:0]      ip_prev;
		logic [3:0]      ip_acc;
		logic [3:0]      ip_chg;
	} uapit_state_t;

endpackage

// [rtl/uapit_ctimer.sv]
// Sixteen-bit down counter/timer with counter, timer and timeout modes.
`timescale 1ns/100ps
`default_nettype none

module uapit_ctimer (
	input  wire logic                    clk_in,
	input  wire logic                    rst_b_in,
	input  wire logic                    tick_in,
	input  wire uapit_pkg::uapit_ct_mode_t mode_in,
	input  wire logic                    start_in,
	input  wire logic                    stop_in,
	input  wire logic                    rx_activity_in,
	input  wire logic [15:0]             preset_in,
	output logic      [15:0]             value_out,
	output logic                         wave_out,
	output logic                         zero_out
);
	import uapit_pkg::*;

	uapit_ct_state_t q;
	uapit_ct_state_t next_q;

	// Count down on each tick and act on every pass through zero.
	always_comb begin
		next_q = q;
		next_q.zero = 1'b0;
		case (mode_in)
			UAPIT_CT_TIMER: begin
				// RULE10 square wave
				// The timer runs free so the wave never stalls a clock user.
				if (tick_in) begin
					if (q.count == 16'h0000) begin
						next_q.count = preset_in;
						next_q.wave = ~q.wave;
						next_q.zero = 1'b1;
					end else begin
						next_q.count = q.count - 16'h0001;
					end
				end
			end
			UAPIT_CT_TIMEOUT: begin
				// RULE11 receiver restarts count
				if (rx_activity_in || start_in) begin
					next_q.count = preset_in;
					next_q.running = 1'b1;
				end else if (stop_in) begin
					next_q.running = 1'b0;
				end else if (q.running && tick_in) begin
					if (q.count == 16'h0000) begin
						next_q.zero = 1'b1;
						next_q.running = 1'b0;
					end else begin
						next_q.count = q.count - 16'h0001;
					end
				end
			end
			default: begin
				// RULE10 single delay
				if (start_in) begin
					next_q.count = preset_in;
					next_q.running = 1'b1;
				end else if (stop_in) begin
					next_q.running = 1'b0;
				end else if (q.running && tick_in) begin
					// RULE12 zero pass
					// After the delay it wraps and keeps counting until stopped.
					next_q.zero = (q.count == 16'h0000);
					next_q.count = q.count - 16'h0001;
				end
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign value_out = q.count;
	assign wave_out  = q.wave;
	assign zero_out  = q.zero;

endmodule

`default_nettype wire

// [test/uapit_host.sv]
// Host processor model that runs bus cycles against the serial support block.
`timescale 1ns/100ps
`default_nettype none

module uapit_host (
	input  wire logic       clk_in,
	input  wire logic       xfer_ack_n_in,
	input  wire logic [7:0] rdata_in,
	output logic            cs_n_out,
	output logic            rw_out,
	output logic      [3:0] addr_out,
	output logic      [7:0] wdata_out,
	output logic            irq_ack_n_out
);
	// The bus is idle at time zero.
	initial begin
		cs_n_out = 1'b1;
		rw_out = 1'b1;
		addr_out = 4'h0;
		wdata_out = 8'h00;
		irq_ack_n_out = 1'b1;
	end

	// One bus cycle; no answer within sixteen edges hands back unknown data, which matches only an expected 8'hXX.
	task automatic cycle(input logic ack, input logic rd, input logic [3:0] a,
		input logic [7:0] wd, output logic [7:0] rdat);
		int n;
		rdat = 8'hXX;
		@(negedge clk_in);
		rw_out = rd;
		addr_out = a;
		wdata_out = wd;
		if (ack) begin
			irq_ack_n_out = 1'b0;
		end else begin
			cs_n_out = 1'b0;
		end
		for (n = 0; n < 16; n++) begin
			@(posedge clk_in);
			if (xfer_ack_n_in === 1'b0) begin
				rdat = rdata_in;
				break;
			end
		end
		@(negedge clk_in);
		cs_n_out = 1'b1;
		irq_ack_n_out = 1'b1;
		// Released lines flip, so a stale value is never mistaken for a live one.
		wdata_out = ~wd;
		addr_out = ~a;
		repeat (2) @(negedge clk_in);
	endtask
endmodule
`default_nettype wire

// [test/uapit_chk.sv]
// Assertion checker for the bus handshake and port pins of the serial support block.
`timescale 1ns/100ps
`default_nettype none

module uapit_chk (
	input wire logic       clk_in,
	input wire logic       rst_b_in,
	input wire logic       cs_n_in,
	input wire logic       rw_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] data_in,
	input wire logic       irq_ack_n_in,
	input wire logic [5:0] in_pin_in,
	input wire logic [7:0] data_out,
	input wire logic       data_oe_b_out,
	input wire logic       xfer_ack_n_out,
	input wire logic       irq_n_out,
	input wire logic [7:0] out_pin_out,
	input wire logic [7:0] out_pin_oe_b_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	logic       idle_rd;
	logic       idle_wr;
	logic [5:0] pin_q;
	logic [2:0] pin_age;

	// A strobe is only taken while no answer stands.
	assign idle_rd = !cs_n_in && rw_in && xfer_ack_n_out;
	assign idle_wr = !cs_n_in && !rw_in && xfer_ack_n_out;

	// Steady-pin age, so the synchroniser delay never makes a read look wrong.
	always_ff @(posedge clk_in) begin
		pin_q <= in_pin_in;
		if (!rst_b_in || in_pin_in != pin_q) begin
			pin_age <= 3'h0;
		end else if (pin_age != 3'h7) begin
			pin_age <= pin_age + 3'h1;
		end
	end

	chk_read_ack: assert property (idle_rd |=> !xfer_ack_n_out && !data_oe_b_out)
		else $error("read not answered with data");
	chk_write_ack: assert property (idle_wr |=> !xfer_ack_n_out && data_oe_b_out)
		else $error("write not acknowledged");
	chk_ack_holds: assert property (!xfer_ack_n_out && !cs_n_in |=> !xfer_ack_n_out)
		else $error("acknowledge dropped under strobe");
	chk_ack_release: assert property (!xfer_ack_n_out && cs_n_in && irq_ack_n_in
		|-> ##[1:2] xfer_ack_n_out) else $error("acknowledge not released");
	chk_vector_ack: assert property (cs_n_in && !irq_ack_n_in && !irq_n_out
		&& xfer_ack_n_out |=> !xfer_ack_n_out && !data_oe_b_out) else $error("vector not given");
	chk_input_read: assert property (idle_rd && addr_in == 4'hD && irq_ack_n_in
		&& pin_age >= 3'h4 |=> data_out == {2'b11, $past(in_pin_in)}) else $error("input read");
	chk_out_set: assert property (idle_wr && addr_in == 4'hE
		|=> ((out_pin_out ^ ($past(out_pin_out) & ~$past(data_in))) & 8'h07) == 8'h00)
		else $error("output set write wrong");
	chk_out_clear: assert property (idle_wr && addr_in == 4'hF
		|=> ((out_pin_out ^ ($past(out_pin_out) | $past(data_in))) & 8'h07) == 8'h00)
		else $error("output clear write wrong");
	chk_gp_push: assert property (out_pin_oe_b_out[2:0] == 3'h0)
		else $error("plain output pin not driven");

	cov_read: cover property (idle_rd ##1 !xfer_ack_n_out);
	cov_vector: cover property (cs_n_in && !irq_ack_n_in && !irq_n_out ##1 !data_oe_b_out);
	cov_set: cover property (idle_wr && addr_in == 4'hE);
endmodule

bind uapit_top uapit_chk u_chk (
	.clk_in          (clk_in),
	.rst_b_in        (rst_b_in),
	.cs_n_in         (cs_n_in),
	.rw_in           (rw_in),
	.addr_in         (addr_in),
	.data_in         (data_in),
	.irq_ack_n_in    (irq_ack_n_in),
	.in_pin_in       (in_pin_in),
	.data_out        (data_out),
	.data_oe_b_out   (data_oe_b_out),
	.xfer_ack_n_out  (xfer_ack_n_out),
	.irq_n_out       (irq_n_out),
	.out_pin_out     (out_pin_out),
	.out_pin_oe_b_out(out_pin_oe_b_out)
);
`default_nettype wire

// [test/uapit_top_tb_top.sv]
// Self-checking bench for the serial support block, driven through the host model.
`timescale 1ns/100ps
`default_nettype none

module uapit_top_tb_top;
	import uapit_pkg::*;
	localparam int HZ = 1600000;
	localparam int SMP = HZ / 38400;
	localparam int DIV9600 = HZ / (16 * 9600);
	logic       clk_in = 1'b0;
	logic       rst_b_in = 1'b0;
	logic [5:0] pins = 6'h2A;
	logic [5:0] src = 6'h00;
	logic       rxact = 1'b0;
	logic       cs_n, rw, iack_n, ack_n, oe_b, irq_n;
	logic [3:0] addr, tick;
	logic [7:0] wdata, rdata, opin, opin_oe;
	int         fails = 0;
	int         check_count = 0;

	// Free-running 100 MHz clock.
	always #5 clk_in = ~clk_in;

	uapit_top #(.CLK_HZ(HZ)) dut (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .cs_n_in(cs_n), .rw_in(rw), .addr_in(addr),
		.data_in(wdata), .irq_ack_n_in(iack_n), .in_pin_in(pins), .tx_rdy_a_in(src[0]),
		.rx_rdy_a_in(src[1]), .brk_a_in(src[2]), .tx_rdy_b_in(src[3]), .rx_rdy_b_in(src[4]),
		.brk_b_in(src[5]), .rx_activity_in(rxact), .data_out(rdata), .data_oe_b_out(oe_b),
		.xfer_ack_n_out(ack_n), .irq_n_out(irq_n), .out_pin_out(opin),
		.out_pin_oe_b_out(opin_oe), .rate_tick_out(tick)
	);

	uapit_host host (
		.clk_in(clk_in), .xfer_ack_n_in(ack_n), .rdata_in(rdata), .cs_n_out(cs_n),
		.rw_out(rw), .addr_out(addr), .wdata_out(wdata), .irq_ack_n_out(iack_n)
	);

	// Comparison and bus shorthands shared by every scenario; interval measurement for the counter scenario.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] x;
		host.cycle(1'b0, 1'b0, a, d, x);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		host.cycle(1'b0, 1'b1, a, 8'h00, d);
	endtask
	task automatic span(input logic sel, output logic [7:0] n);
		logic p;
		int   k, first;
		first = -1;
		n = 8'hXX;
		p = opin[3];
		for (k = 0; k < 300; k++) begin
			@(negedge clk_in);
			if (sel ? tick[0] : (opin[3] != p)) begin
				if (first >= 0) begin
					n = 8'(k - first);
					break;
				end
				first = k;
			end
			p = opin[3];
		end
	endtask

	task automatic t_reset;
		logic [7:0] d;
		check(opin, 8'hFF);
		check(opin_oe, 8'h00);
		check({7'h00, irq_n}, 8'h01);
		rd(4'h8, d);
		check(d, 8'h00);
	endtask

	task automatic t_outport;
		wr(4'hE, 8'h05);
		check(opin, 8'hFA);
		wr(4'hE, 8'h80);
		check(opin, 8'h7A);
		wr(4'hF, 8'h84);
		check(opin, 8'hFE);
		wr(4'hD, 8'h04);
		@(negedge clk_in);
		src = 6'h02;
		repeat (3) @(negedge clk_in);
		check({6'h00, opin[4], opin_oe[4]}, 8'h00);
		src = 6'h00;
		repeat (3) @(negedge clk_in);
		check({7'h00, opin_oe[4]}, 8'h01);
		wr(4'hD, 8'h00);
	endtask

	task automatic t_irq;
		logic [7:0] d, bit_v;
		int         i;
		for (i = 0; i < 6; i++) begin
			bit_v = 8'h01 << ((i < 3) ? i : i + 1);
			@(negedge clk_in);
			src = 6'h01 << i;
			wr(4'h5, ~bit_v);
			check({7'h00, irq_n}, 8'h01);
			rd(4'h5, d);
			check(d, bit_v);
			wr(4'h5, bit_v);
			check({7'h00, irq_n}, 8'h00);
		end
		wr(4'hC, 8'hA5);
		host.cycle(1'b1, 1'b1, 4'h0, 8'h00, d);
		check(d, 8'hA5);
		src = 6'h00;
		repeat (3) @(negedge clk_in);
		host.cycle(1'b1, 1'b1, 4'h0, 8'h00, d);
		check(d, 8'hXX);
		wr(4'h5, 8'h00);
	endtask

	task automatic t_ports;
		logic [7:0] d;
		@(negedge clk_in);
		pins = 6'h15;
		repeat (4) @(negedge clk_in);
		rd(4'hD, d);
		check(d, 8'hD5);
		repeat (3 * SMP) @(negedge clk_in);
		rd(4'h4, d);
		wr(4'h4, 8'h0F);
		wr(4'h5, 8'h80);
		// A one-cycle glitch on pin 1 is followed by a lasting change on pin 0.
		pins[1] = 1'b1;
		@(negedge clk_in);
		pins[1] = 1'b0;
		pins[0] = 1'b0;
		rd(4'h4, d);
		check(d, 8'h50);
		repeat (2 * SMP) @(negedge clk_in);
		check({7'h00, irq_n}, 8'h00);
		rd(4'h4, d);
		check(d, 8'h41);
		rd(4'h4, d);
		check(d, 8'h40);
		check({7'h00, irq_n}, 8'h01);
		wr(4'h5, 8'h08);
	endtask

	task automatic t_counter;
		logic [7:0] d;
		wr(4'h6, 8'h00);
		wr(4'h7, 8'h03);
		wr(4'h4, 8'h10);
		wr(4'hD, 8'h01);
		rd(4'hE, d);
		span(1'b0, d);
		check(d, 8'h04);
		wr(4'h1, 8'h12);
		span(1'b1, d);
		check(d, 8'h04);
		wr(4'h1, 8'h0D);
		span(1'b1, d);
		check(d, 8'(DIV9600));
		wr(4'h4, 8'h00);
		rd(4'hF, d);
		check({7'h00, irq_n}, 8'h01);
		rd(4'hE, d);
		repeat (10) @(negedge clk_in);
		check({7'h00, irq_n}, 8'h00);
		rd(4'hF, d);
		rd(4'h5, d);
		check(d & 8'h08, 8'h00);
	endtask

	task automatic t_timeout;
		logic [7:0] d;
		wr(4'hA, 8'h01);
		// Activity every other cycle keeps reloading the count, so it must never expire.
		repeat (10) begin
			@(negedge clk_in);
			rxact = 1'b1;
			@(negedge clk_in);
			rxact = 1'b0;
		end
		check({7'h00, irq_n}, 8'h01);
		repeat (10) @(negedge clk_in);
		check({7'h00, irq_n}, 8'h00);
		rd(4'hF, d);
		wr(4'hA, 8'h00);
	endtask

	// Verdict and end of run; the watchdog lands here as well.
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// The scenarios take under a thousand cycles; twenty thousand means a hang.
	initial begin
		repeat (20000) @(posedge clk_in);
		fails++;
		final_report;
	end

	// Main sequence after an eight-cycle reset.
	initial begin
		repeat (8) @(negedge clk_in);
		rst_b_in = 1'b1;
		repeat (2) @(negedge clk_in);
		t_reset;
		t_outport;
		t_irq;
		t_ports;
		t_counter;
		t_timeout;
		final_report;
	end
endmodule
`default_nettype wire
